// ===== hdl/rscp_map.svh
// Purpose: Constants of the radio serial command port
// Assumes: Included by the port logic only
// Notes: Command codes, status bit places
`ifndef RSCP_MAP_SVH
`define RSCP_MAP_SVH
// Command codes
`define RSCP_CMD_NOP 8'hff
`define RSCP_CMD_PKT_WR 8'h10
`define RSCP_CMD_PKT_RD 8'h30
`define RSCP_CMD_FW_WR 8'h1e
// Upper five bits of address-carrying codes
`define RSCP_GRP_SEQ_WR 5'h03
`define RSCP_GRP_SEQ_RD 5'h07
`define RSCP_GRP_RND_WR 5'h01
`define RSCP_GRP_RND_RD 5'h05
// Radio controller code range
`define RSCP_CMD_RC_LO 8'hb1
`define RSCP_CMD_RC_HI 8'hb7
`define RSCP_CMD_PC_CLR 8'hc7
`define RSCP_CMD_DEV_RST 8'hc8
// Status word bit places
`define RSCP_ST_MEM_RDY 7
`define RSCP_ST_IRQ 6
`define RSCP_ST_RC_RDY 5
`define RSCP_ST_CCA 4
// Firmware memory start address
`define RSCP_FW_BASE 11'h000
`endif

// ===== hdl/rscp_pkg.sv
// Purpose: Types of the radio serial command port
// Assumes: Constants live in rscp_map.svh
// Notes: One-hot decoder states
package rscp_pkg;
  typedef enum logic [3:0] {
    RSCP_CMD = 4'h1, // Awaiting a command byte
    RSCP_MEM = 4'h2, // Memory access command active
    RSCP_RC = 4'h4,  // Radio command held until deselect
    RSCP_IGN = 4'h8  // Further bytes ignored
  } rscp_state_t;
endpackage

// ===== hdl/rscp_top.sv
// Purpose: Serial slave command port of a radio transceiver
// Assumes: Serial pins asynchronous to clk_i, slow clock mode 0
// Notes: Memory and radio controllers sit outside on clk_i
`timescale 1ns/1ps
`include "rscp_map.svh"

module rscp_top
  import rscp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial pins from the host
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // Interrupt pins mirrored into status
  input wire logic interrupt_pin_one_i,
  input wire logic interrupt_pin_two_i,
  // Status sources, clk_i domain
  input wire logic mem_ready_i,
  input wire logic radio_ctrl_accepts_flag_i,
  input wire logic cca_idle_i,
  input wire logic [3:0] radio_state_field_i,
  // Packet base pointers
  input wire logic [7:0] tx_base_i,
  input wire logic [7:0] rx_base_i,
  // Radio controller command strobe
  output logic rc_cmd_valid_o,
  output logic [7:0] rc_cmd_o,
  // Memory controller
  output logic mem_exec_o,
  output logic [7:0] mem_cmd_o,
  output logic mem_we_o,
  output logic mem_re_o,
  output logic [10:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i
);

  // ***************************************
  // Pin synchronisers
  // ***************************************
  logic [4:0] sync1_q; // First stage, read by stage two only
  logic [4:0] sync2_q; // Stable copies
  logic sclk_prev_q;   // Edge finder for serial clock
  logic cs_prev_q;     // Edge finder for select

  // Two flops on every pin
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 5'h02;
      sync2_q <= 5'h02;
    end else begin
      sync1_q <= {interrupt_pin_two_i, interrupt_pin_one_i,
                  mosi_i, cs_n_i, sclk_i};
      sync2_q <= sync1_q;
    end
  end
  wire logic s_sclk = sync2_q[0]; // Synced serial clock
  wire logic s_cs_n = sync2_q[1]; // Synced select
  wire logic s_mosi = sync2_q[2]; // Synced data in
  // Previous samples for edges
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= s_sclk;
      cs_prev_q <= s_cs_n;
    end
  end
  wire logic sel = ~s_cs_n; // Port selected
  wire logic cs_fall = cs_prev_q & ~s_cs_n; // Select just asserted
  wire logic cs_rise = ~cs_prev_q & s_cs_n; // Select just released
  wire logic sck_rise = sel & s_sclk & ~sclk_prev_q;
  wire logic sck_fall = sel & ~s_sclk & sclk_prev_q;
  // ***************************************
  // Status word
  // ***************************************
  logic [7:0] status_w;
  always_comb begin
    status_w = {4'h0, radio_state_field_i};
    status_w[`RSCP_ST_MEM_RDY] = mem_ready_i;
    status_w[`RSCP_ST_IRQ] = sync2_q[3] | sync2_q[4];
    status_w[`RSCP_ST_RC_RDY] = radio_ctrl_accepts_flag_i;
    status_w[`RSCP_ST_CCA] = cca_idle_i;
  end

  // ***************************************
  // Receive shifter
  // ***************************************
  logic [6:0] rx_q;     // Bits gathered so far
  logic [2:0] bit_cnt_q; // Bit within byte
  wire logic [7:0] rx_byte = {rx_q, s_mosi};
  wire logic byte_done = sck_rise & (bit_cnt_q == 3'h7); // Eighth bit sampled
  // Shift in on rising edges, MSB first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_q <= 7'h00;
      bit_cnt_q <= 3'h0;
    end else if (!sel) begin
      // Frame boundary restarts byte alignment
      bit_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      rx_q <= rx_byte[6:0];
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // ***************************************
  // Transmit shifter
  // ***************************************
  logic [7:0] tx_q;    // MISO comes from bit 7
  logic oe_q;          // Drive enable
  logic rd_pend_q;     // Read data owed next byte
  logic [7:0] rdata_q; // Captured read data
  logic re_dly_q;      // Read data valid this cycle
  // Load status on select, shift on falling edges
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      oe_q <= sel;
      if (cs_fall) begin
        tx_q <= status_w;
      end else if (sck_fall) begin
        if (bit_cnt_q == 3'h0) begin
          // Next byte: read data or status
          tx_q <= rd_pend_q ? rdata_q : status_w;
        end else begin
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  assign miso_o = tx_q[7];
  assign miso_oe_o = oe_q;
  // ***************************************
  // Command decoder
  // ***************************************
  rscp_state_t st_q;
  logic [7:0] cmd_q;   // Recognised command
  logic nop_seen_q;    // First byte was a no-op
  logic first_q;       // Next rising edge opens first param
  logic addr_ok_q;     // Address known for data bytes
  logic [10:0] addr_q; // Working memory address
  // Command classes
  wire logic is_fw = (cmd_q == `RSCP_CMD_FW_WR);
  wire logic is_pkt_wr = (cmd_q == `RSCP_CMD_PKT_WR);
  wire logic is_pkt_rd = (cmd_q == `RSCP_CMD_PKT_RD);
  wire logic is_rnd = (cmd_q[7:3] == `RSCP_GRP_RND_WR) |
                      (cmd_q[7:3] == `RSCP_GRP_RND_RD);
  wire logic is_wr = ~cmd_q[5]; // Write codes have bit 5 clear
  wire logic is_mem_byte = (rx_byte == `RSCP_CMD_PKT_WR) |
                           (rx_byte == `RSCP_CMD_PKT_RD) |
                           (rx_byte[7:3] == `RSCP_GRP_SEQ_WR) |
                           (rx_byte[7:3] == `RSCP_GRP_SEQ_RD) |
                           (rx_byte[7:3] == `RSCP_GRP_RND_WR) |
                           (rx_byte[7:3] == `RSCP_GRP_RND_RD);
  wire logic is_rc_byte = ((rx_byte >= `RSCP_CMD_RC_LO) &&
                           (rx_byte <= `RSCP_CMD_RC_HI)) |
                          (rx_byte == `RSCP_CMD_PC_CLR) |
                          (rx_byte == `RSCP_CMD_DEV_RST);
  // Low address byte joined to the high bits from the command
  wire logic [10:0] new_addr = {addr_q[10:8], rx_byte};
  // Decoder state and memory sequencing
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= RSCP_CMD;
      cmd_q <= `RSCP_CMD_NOP;
      nop_seen_q <= 1'b0;
      first_q <= 1'b0;
      addr_ok_q <= 1'b0;
      addr_q <= 11'h000;
    end else if (cs_fall) begin
      st_q <= RSCP_CMD;
      nop_seen_q <= 1'b0;
      first_q <= 1'b0;
      addr_ok_q <= 1'b0;
    end else begin
      case (st_q)
        RSCP_CMD: begin
          if (byte_done) begin
            cmd_q <= rx_byte;
            if (rx_byte == `RSCP_CMD_NOP) begin
              // Second no-op still allowed
              nop_seen_q <= 1'b1;
              st_q <= nop_seen_q ? RSCP_IGN : RSCP_CMD;
            end else if (is_mem_byte) begin
              st_q <= RSCP_MEM;
              first_q <= 1'b1;
            end else if (is_rc_byte) begin
              st_q <= RSCP_RC;
            end else begin
              st_q <= RSCP_IGN;
            end
          end
        end
        RSCP_MEM: begin
          if (sck_rise && first_q) begin
            // Execute on first parameter MSB
            first_q <= 1'b0;
            if (is_pkt_wr) begin
              addr_q <= {3'h0, tx_base_i};
              addr_ok_q <= 1'b1;
            end else if (is_pkt_rd) begin
              addr_q <= {3'h0, rx_base_i};
              addr_ok_q <= 1'b1;
            end else if (is_fw) begin
              addr_q <= `RSCP_FW_BASE;
              addr_ok_q <= 1'b1;
            end else begin
              addr_q <= {cmd_q[2:0], 8'h00};
            end
          end else if (byte_done) begin
            if (!addr_ok_q) begin
              // Low address byte
              addr_ok_q <= 1'b1;
              addr_q <= (!is_wr && !is_rnd) ? new_addr + 11'h001 : new_addr;
            end else if (is_rnd) begin
              // Pair done, next byte is an address
              addr_ok_q <= 1'b0;
            end else begin
              addr_q <= addr_q + 11'h001;
            end
          end
        end
        RSCP_RC: st_q <= RSCP_RC; // Further bytes ignored
        RSCP_IGN: st_q <= RSCP_IGN;
        default: st_q <= RSCP_IGN;
      endcase
    end
  end

  // ***************************************
  // Memory strobes
  // ***************************************
  // Byte belongs to an active memory access
  wire logic mem_body = (st_q == RSCP_MEM) & byte_done & ~first_q;
  // Write, read and execute strobes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_exec_o <= 1'b0;
      mem_cmd_o <= 8'h00;
      mem_we_o <= 1'b0;
      mem_re_o <= 1'b0;
      mem_addr_o <= 11'h000;
      mem_wdata_o <= 8'h00;
    end else begin
      mem_exec_o <= (st_q == RSCP_MEM) & sck_rise & first_q;
      if ((st_q == RSCP_MEM) && sck_rise && first_q) begin
        mem_cmd_o <= cmd_q;
      end
      mem_we_o <= 1'b0;
      mem_re_o <= 1'b0;
      if (mem_body) begin
        if (addr_ok_q && is_wr) begin
          // Data byte to memory
          mem_we_o <= 1'b1;
          mem_addr_o <= addr_q;
          mem_wdata_o <= rx_byte;
        end else if (!addr_ok_q && !is_wr) begin
          // Address just arrived, prefetch
          mem_re_o <= 1'b1;
          mem_addr_o <= new_addr;
        end else if (addr_ok_q && !is_wr && !is_rnd) begin
          mem_re_o <= 1'b1;
          mem_addr_o <= addr_q;
        end
      end
    end
  end
  // Capture read data, owe it to next byte
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      re_dly_q <= 1'b0;
      rdata_q <= 8'h00;
      rd_pend_q <= 1'b0;
    end else begin
      re_dly_q <= mem_re_o;
      if (re_dly_q) begin
        rdata_q <= mem_rdata_i;
        rd_pend_q <= 1'b1;
      end else if (!sel || (sck_fall && bit_cnt_q == 3'h0)) begin
        rd_pend_q <= 1'b0;
      end
    end
  end
  // ***************************************
  // Radio controller strobe
  // ***************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rc_cmd_valid_o <= 1'b0;
      rc_cmd_o <= 8'h00;
    end else begin
      // Executes only once select returns high
      rc_cmd_valid_o <= cs_rise & (st_q == RSCP_RC);
      if (cs_rise && st_q == RSCP_RC) begin
        rc_cmd_o <= cmd_q;
      end
    end
  end
  // ***************************************
  // Checks
  // ***************************************
  a_oe_tracks_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    miso_oe_o == $past(sel)) else $error("miso enable wrong");
  a_msb_on_select: assert property (@(posedge clk_i) disable iff (rst_i)
    cs_fall |=> (miso_o == $past(status_w[7]))) else $error("status msb missing");
  a_rc_at_release: assert property (@(posedge clk_i) disable iff (rst_i)
    rc_cmd_valid_o |-> $past(cs_rise) && s_cs_n) else $error("radio strobe early");
  a_rc_code_range: assert property (@(posedge clk_i) disable iff (rst_i)
    rc_cmd_valid_o |-> (rc_cmd_o[7:4] == 4'hb || rc_cmd_o[7:4] == 4'hc))
    else $error("radio code bad");
  a_exec_first_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_exec_o |-> $past(sck_rise) && $past(bit_cnt_q) == 3'h0)
    else $error("memory exec misplaced");
  a_we_on_byte: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_we_o |-> $past(byte_done) && $past(rx_byte) == mem_wdata_o)
    else $error("write data wrong");
  a_seq_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    (mem_we_o && !is_rnd && st_q == RSCP_MEM && !cs_fall) |->
    addr_q == mem_addr_o + 11'h001) else $error("address not advanced");
  a_one_command: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == RSCP_RC && !cs_fall) |=> st_q == RSCP_RC) else $error("second command");
  a_status_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    cs_fall && (sync2_q[3] || sync2_q[4]) |=> tx_q[6])
    else $error("irq status missing");
endmodule

// ===== dv/rscp_host_model.sv
// Purpose: Host master model that drives the serial command port
// Assumes: Mode 0, sclk idle low, four clk_i cycles per sclk half period
// Notes: A MISO bit sampled while the driver is off reads as unknown
`timescale 1ns/1ps

module rscp_host_model (
  // Clock
  input wire logic clk_i,
  // Serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  // ************************************
  // Idle levels and byte tasks
  // ************************************
  // Deselected, clock parked low
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  // Select, then leave time for the status MSB to appear
  task automatic open_sel();
    tick(1);
    cs_n_o = 1'b0;
    tick(6);
  endtask

  // Deselect after each command; MOSI flips so no stale level lingers
  task automatic close_sel();
    tick(4);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    tick(8);
  endtask

  // One byte MSB first; MISO taken just before each rise
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = b[i];
      tick(4);
      r[i] = miso_oe_i ? miso_i : 1'bx;
      sclk_o = 1'b1;
      tick(4);
      sclk_o = 1'b0;
    end
  endtask
endmodule

// ===== dv/testbench.sv
// Purpose: Self-checking bench for the radio serial command port
// Assumes: Memory read data answers within the read strobe's cycle
// Notes: Strobes are logged on the falling clk_i edge, where they are settled
`timescale 1ns/1ps

module testbench;
  import rscp_pkg::*;
  // ************************************
  // Signals, models and logs
  // ************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk, cs_n, mosi, miso, miso_oe;
  logic [8:0] st_in = 9'h135; // mem, irq1, irq2, radio_ctrl_accepts_flag, cca, state
  logic [7:0] tx_base = 8'h40;
  logic [7:0] rx_base = 8'h80;
  logic [7:0] rdata = 8'h00;
  logic rc_v, m_exec, m_we, m_re;
  logic [7:0] rc_cmd, m_cmd, m_wd;
  logic [10:0] m_addr;
  logic [7:0] rcq[$], eq[$], rx[$];
  logic [18:0] wq[$];
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;

  always #12.5 clk_i = ~clk_i;

  rscp_host_model host (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso), .miso_oe_i(miso_oe));

  rscp_top DUT (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .interrupt_pin_one_i(st_in[7]),
    .interrupt_pin_two_i(st_in[6]), .mem_ready_i(st_in[8]),
    .radio_ctrl_accepts_flag_i(st_in[5]), .cca_idle_i(st_in[4]),
    .radio_state_field_i(st_in[3:0]), .tx_base_i(tx_base), .rx_base_i(rx_base),
    .rc_cmd_valid_o(rc_v), .rc_cmd_o(rc_cmd), .mem_exec_o(m_exec), .mem_cmd_o(m_cmd),
    .mem_we_o(m_we), .mem_re_o(m_re), .mem_addr_o(m_addr), .mem_wdata_o(m_wd),
    .mem_rdata_i(rdata));

  // Memory content is a fixed mix of the address
  function automatic logic [7:0] mem_of(input logic [10:0] a);
    mem_of = a[7:0] ^ {a[10:8], 5'h0a};
  endfunction

  // Strobe logs and the memory answer
  always @(negedge clk_i) begin
    if (rc_v === 1'b1) rcq.push_back(rc_cmd);
    if (m_exec === 1'b1) eq.push_back(m_cmd);
    if (m_we === 1'b1) wq.push_back({m_addr, m_wd});
    if (m_re === 1'b1) rdata = mem_of(m_addr);
  end

  // Hang guard, about five times the expected run
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  // ************************************
  // Compare, transfer and closing tasks
  // ************************************
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_wr(input string n, input logic [18:0] e, input logic [18:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Shift a run of bytes inside an open selection
  task automatic bytes(input logic [7:0] b[$]);
    logic [7:0] r;
    foreach (b[i]) begin
      host.xfer(b[i], r);
      rx.push_back(r);
    end
  endtask

  // Whole frame: select, bytes, deselect
  task automatic frame(input logic [7:0] b[$]);
    rx.delete();
    host.open_sel();
    bytes(b);
    host.close_sel();
  endtask

  function automatic logic [7:0] exp_st();
    exp_st = {st_in[8], st_in[7] | st_in[6], st_in[5:0]};
  endfunction

  function automatic logic [7:0] pop8(inout logic [7:0] q[$]);
    pop8 = (q.size() != 0) ? q.pop_front() : 8'hxx;
  endfunction

  function automatic logic [18:0] popw();
    popw = (wq.size() != 0) ? wq.pop_front() : 19'hx;
  endfunction

  task automatic results();
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************************************
  // Test sequence
  // ************************************
  logic [8:0] stv[4] = '{9'h161, 9'h094, 9'h0e3, 9'h135};
  logic [7:0] rcc[9] = '{8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7, 8'hc7, 8'hc8};

  initial begin
    repeat (4) @(posedge clk_i);
    #2 rst_i = 1'b0;
    host.tick(4);
    chk_byte("oe_idle", 8'h00, {7'h00, miso_oe});
    // Status word mixes; a third byte after two no-ops is dropped
    foreach (stv[k]) begin
      st_in = stv[k];
      frame('{8'hff, 8'hff, 8'hb2});
      chk_byte("status0", exp_st(), rx[0]);
      chk_byte("status1", exp_st(), rx[1]);
      chk_byte("rc_none", 8'h00, 8'(rcq.size()));
    end
    chk_byte("radio_ctrl_accepts_flag", 8'h01, {7'h00, rx[1][5]});
    // Every radio code, executed only at deselect
    foreach (rcc[i]) begin
      rx.delete();
      host.open_sel();
      bytes('{rcc[i]});
      chk_byte("rc_early", 8'h00, 8'(rcq.size()));
      host.close_sel();
      chk_byte("rc_cmd", rcc[i], pop8(rcq));
    end
    frame('{8'hff, 8'hb2});
    chk_byte("nop_then_rc", 8'hb2, pop8(rcq));
    frame('{8'hb2, 8'hb3});
    chk_byte("one_per_sel", 8'hb2, pop8(rcq));
    frame('{8'h55});
    chk_byte("unknown", 8'h00, 8'(rcq.size() + eq.size()));
    // Sequential write across the top address, radio busy meanwhile
    st_in = 9'h101;
    rx.delete();
    host.open_sel();
    bytes('{8'h1f});
    chk_byte("exec_early", 8'h00, 8'(eq.size()));
    bytes('{8'hff, 8'haa, 8'hbb});
    chk_byte("seq_exec", 8'h1f, pop8(eq));
    host.close_sel();
    chk_wr("seq_w0", {11'h7ff, 8'haa}, popw());
    chk_wr("seq_w1", {11'h000, 8'hbb}, popw());
    // Packet and firmware writes from their bases
    frame('{8'h10, 8'h11, 8'h22});
    chk_byte("pkt_exec", 8'h10, pop8(eq));
    chk_wr("pkt_w0", {11'h040, 8'h11}, popw());
    chk_wr("pkt_w1", {11'h041, 8'h22}, popw());
    frame('{8'h1e, 8'h33});
    chk_byte("fw_exec", 8'h1e, pop8(eq));
    chk_wr("fw_w0", {11'h000, 8'h33}, popw());
    // Random block write pairs
    frame('{8'h0b, 8'h22, 8'h77, 8'h23, 8'h88});
    chk_byte("rnd_exec", 8'h0b, pop8(eq));
    chk_wr("rnd_w0", {11'h322, 8'h77}, popw());
    chk_wr("rnd_w1", {11'h323, 8'h88}, popw());
    // Reads: status first, then data in place of status
    frame('{8'h3b, 8'hfe, 8'hff, 8'hff});
    chk_byte("seqr_exec", 8'h3b, pop8(eq));
    chk_byte("seqr_st", exp_st(), rx[1]);
    chk_byte("seqr_d0", mem_of(11'h3fe), rx[2]);
    chk_byte("seqr_d1", mem_of(11'h3ff), rx[3]);
    frame('{8'h30, 8'hff, 8'hff, 8'hff});
    chk_byte("pktr_st", exp_st(), rx[1]);
    chk_byte("pktr_d0", mem_of(11'h080), rx[2]);
    chk_byte("pktr_d1", mem_of(11'h081), rx[3]);
    frame('{8'h29, 8'h10, 8'hff});
    chk_byte("rndr_d0", mem_of(11'h110), rx[2]);
    chk_byte("stray", 8'h00, 8'(wq.size() + rcq.size()));
    chk_byte("oe_off", 8'h00, {7'h00, miso_oe});
    results();
  end
endmodule
